// ===== hdl/pac_pkg.sv
// Package for the auto-calibration and detector configuration bank.
// Assumes a 24-bit register word and a 200 MHz system clock.
`default_nettype none
package pac_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 6;
  // Register indices
  localparam logic [5:0] ADDR_CAL = 6'h0a;
  localparam logic [5:0] ADDR_DET = 6'h0b;
  localparam logic [5:0] ADDR_EXACT = 6'h0c;
  localparam logic [5:0] ADDR_OSC_LINK = 6'h05;
  // Reset values
  localparam logic [23:0] RST_CAL = 24'h002205;
  localparam logic [23:0] RST_DET = 24'h0f8061;
  localparam logic [23:0] RST_EXACT = 24'h000000;
  // Calibration register fields
  localparam int unsigned CAL_RES_LSB = 0;
  localparam int unsigned CAL_CURVE_LSB = 3;
  localparam int unsigned CAL_WAIT_LSB = 6;
  localparam int unsigned CAL_SAR_LSB = 8;
  localparam int unsigned CAL_FORCE_BIT = 10;
  localparam int unsigned CAL_BYPASS_BIT = 11;
  localparam int unsigned CAL_NOTRIG_BIT = 12;
  localparam int unsigned CAL_CLKSEL_LSB = 13;
  localparam int unsigned CAL_FALL_BIT = 15;
  // Detector register fields
  localparam int unsigned DET_DELAY_LSB = 0;
  localparam int unsigned DET_SHORT_BIT = 3;
  localparam int unsigned DET_POL_BIT = 4;
  localparam int unsigned DET_UP_BIT = 5;
  localparam int unsigned DET_DN_BIT = 6;
  localparam int unsigned DET_CSP_LSB = 7;
  localparam int unsigned DET_FUP_BIT = 9;
  localparam int unsigned DET_FDN_BIT = 10;
  localparam int unsigned DET_FMID_BIT = 11;
  localparam int unsigned DET_GATE_LSB = 17;
  // Exact-frequency field
  localparam int unsigned EXACT_W = 14;
  localparam logic [13:0] EXACT_MIN = 14'h0002;
  // Timing: wait states last this many calibration-machine periods
  localparam int unsigned CAL_WAIT_PERIODS = 100;
  // Reference divide ratios for clock-select codes 0..3
  localparam logic [5:0] REF_DIV0 = 6'h01;
  localparam logic [5:0] REF_DIV1 = 6'h04;
  localparam logic [5:0] REF_DIV2 = 6'h10;
  localparam logic [5:0] REF_DIV3 = 6'h20;
  localparam int unsigned MEAS_W = 9;

  typedef struct packed {
    logic [2:0] reset_delay;
    logic inputs_shorted;
    logic polarity_inverted;
    logic up_enable;
    logic down_enable;
    logic [1:0] cycle_slip_select;
    logic force_up;
    logic force_down;
    logic force_mid_rail;
    logic [1:0] counter_clock_gating;
  } pac_det_ctrl_s;

  typedef struct packed {
    logic [8:0] meas_cycles;
    logic signed [3:0] curve_offset;
    logic [1:0] wait_after_cycles;
    logic [1:0] curve_search_bit_count;
    logic force_curve;
    logic bypass_tuning;
  } pac_cal_ctrl_s;
endpackage
`default_nettype wire

// ===== hdl/pac_cal_clk.sv
// Calibration-machine clock enable from the reference pin.
// Assumes each reference level holds for three CLK cycles or more.
`default_nettype none
module pac_cal_clk (
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic ce,
  // Reference pin and selection
  input wire logic ref_pin,
  input wire logic [1:0] div_sel,
  input wire logic use_falling,
  // Tick out
  output logic tick
);
  logic [2:0] sync_r, sync_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;
  logic lvl_r, lvl_nxt;
  logic agree;
  logic [5:0] div;
  logic edge_seen;

  always_comb begin
    sync_nxt = {sync_r[1:0], ref_pin};
    unique case (div_sel)
      2'd0: div = pac_pkg::REF_DIV0;
      2'd1: div = pac_pkg::REF_DIV1;
      2'd2: div = pac_pkg::REF_DIV2;
      default: div = pac_pkg::REF_DIV3;
    endcase
    // Edge once the second and third stages agree on a new level
    agree = (sync_r[1] == sync_r[2]);
    lvl_nxt = agree ? sync_r[2] : lvl_r;
    edge_seen = agree && (sync_r[2] != lvl_r)
                && (use_falling ? lvl_r : sync_r[2]);
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (edge_seen) begin
      if (cnt_r >= div - 6'd1) begin
        cnt_nxt = 6'd0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 6'd1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_r <= 3'h0;
      cnt_r <= 6'h00;
      tick_r <= 1'b0;
      lvl_r <= 1'b0;
    end else if (ce) begin
      sync_r <= sync_nxt;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule // pac_cal_clk
`default_nettype wire

// ===== hdl/pac_config_regs.sv
// Configuration bank: auto-calibration, detector and exact-frequency words.
// Assumes the serial control port presents decoded word writes and reads.
`default_nettype none
module pac_config_regs (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  // Register access from the serial port
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [23:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [23:0] REG_RDATA,
  // Reference pin
  input wire logic REF_PIN,
  // Calibration machine controls
  output logic CAL_TICK,
  output pac_pkg::pac_cal_ctrl_s CAL_CTRL,
  output logic [6:0] CAL_WAIT_LEN,
  // Oscillator link trigger
  output logic OSC_LINK_TRIGGER,
  // Detector and pump controls
  output pac_pkg::pac_det_ctrl_s DET_CTRL,
  // Exact frequency
  output logic [13:0] EXACT_CHANNELS,
  output logic EXACT_ENABLE
);
  logic [23:0] cal_r, cal_nxt;
  logic [23:0] det_r, det_nxt;
  logic [13:0] exact_r, exact_nxt;
  logic [23:0] rdata_r, rdata_nxt;
  logic trig_r, trig_nxt;
  pac_pkg::pac_cal_ctrl_s calc_r, calc_nxt;
  pac_pkg::pac_det_ctrl_s detc_r, detc_nxt;
  logic exen_r, exen_nxt;
  logic [2:0] res;
  logic [2:0] curve;

  // Register writes and reads
  always_comb begin
    cal_nxt = cal_r;
    det_nxt = det_r;
    exact_nxt = exact_r;
    rdata_nxt = rdata_r;
    if (REG_WR) begin
      unique case (REG_ADDR)
        pac_pkg::ADDR_CAL: cal_nxt = REG_WDATA;
        pac_pkg::ADDR_DET: det_nxt = REG_WDATA;
        pac_pkg::ADDR_EXACT: exact_nxt = REG_WDATA[13:0];
        default: ;
      endcase
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        pac_pkg::ADDR_CAL: rdata_nxt = cal_r;
        pac_pkg::ADDR_DET: rdata_nxt = det_r;
        pac_pkg::ADDR_EXACT: rdata_nxt = {10'h000, exact_r};
        default: rdata_nxt = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cal_r <= pac_pkg::RST_CAL;
      det_r <= pac_pkg::RST_DET;
      exact_r <= pac_pkg::RST_EXACT[13:0];
      rdata_r <= 24'h000000;
    end else if (CE) begin
      cal_r <= cal_nxt;
      det_r <= det_nxt;
      exact_r <= exact_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Decoded controls
  always_comb begin
    res = cal_r[pac_pkg::CAL_RES_LSB +: 3];
    curve = cal_r[pac_pkg::CAL_CURVE_LSB +: 3];
    calc_nxt.meas_cycles = (res < 3'd4)
      ? 9'(9'h001 << res) : 9'(9'h001 << (4'(res) + 4'd1));
    calc_nxt.curve_offset = curve[2]
      ? 4'($signed({1'b1, curve}) - 4'sd0) : $signed({1'b0, curve});
    calc_nxt.wait_after_cycles = cal_r[pac_pkg::CAL_WAIT_LSB +: 2];
    calc_nxt.curve_search_bit_count = cal_r[pac_pkg::CAL_SAR_LSB +: 2];
    calc_nxt.force_curve = cal_r[pac_pkg::CAL_FORCE_BIT];
    calc_nxt.bypass_tuning = cal_r[pac_pkg::CAL_BYPASS_BIT];
    detc_nxt.reset_delay = det_r[pac_pkg::DET_DELAY_LSB +: 3];
    detc_nxt.inputs_shorted = det_r[pac_pkg::DET_SHORT_BIT];
    detc_nxt.polarity_inverted = det_r[pac_pkg::DET_POL_BIT];
    detc_nxt.up_enable = det_r[pac_pkg::DET_UP_BIT];
    detc_nxt.down_enable = det_r[pac_pkg::DET_DN_BIT];
    detc_nxt.cycle_slip_select = det_r[pac_pkg::DET_CSP_LSB +: 2];
    detc_nxt.force_up = det_r[pac_pkg::DET_FUP_BIT];
    detc_nxt.force_down = det_r[pac_pkg::DET_FDN_BIT];
    detc_nxt.force_mid_rail = det_r[pac_pkg::DET_FMID_BIT];
    detc_nxt.counter_clock_gating = det_r[pac_pkg::DET_GATE_LSB +: 2];
    exen_nxt = (exact_r >= pac_pkg::EXACT_MIN);
    // A write to the link word starts a transfer unless suppressed
    trig_nxt = REG_WR && (REG_ADDR == pac_pkg::ADDR_OSC_LINK)
               && !cal_r[pac_pkg::CAL_NOTRIG_BIT];
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      calc_r <= '0;
      detc_r <= '0;
      exen_r <= 1'b0;
      trig_r <= 1'b0;
    end else if (CE) begin
      calc_r <= calc_nxt;
      detc_r <= detc_nxt;
      exen_r <= exen_nxt;
      trig_r <= trig_nxt;
    end
  end

  pac_cal_clk u_cal_clk (
    .CLK(CLK),
    .RST_B(RST_B),
    .ce(CE),
    .ref_pin(REF_PIN),
    .div_sel(cal_r[pac_pkg::CAL_CLKSEL_LSB +: 2]),
    .use_falling(cal_r[pac_pkg::CAL_FALL_BIT]),
    .tick(CAL_TICK)
  );

  assign REG_RDATA = rdata_r;
  assign CAL_CTRL = calc_r;
  assign CAL_WAIT_LEN = 7'(pac_pkg::CAL_WAIT_PERIODS);
  assign OSC_LINK_TRIGGER = trig_r;
  assign DET_CTRL = detc_r;
  assign EXACT_CHANNELS = exact_r;
  assign EXACT_ENABLE = exen_r;

  // Checks
  property p_trig_block;
    @(posedge CLK) disable iff (!RST_B)
    (CE && REG_WR && REG_ADDR == pac_pkg::ADDR_OSC_LINK
     && cal_r[pac_pkg::CAL_NOTRIG_BIT]) |=> !OSC_LINK_TRIGGER;
  endproperty
  a_trig_block: assert property (p_trig_block)
    else $error("Link trigger not suppressed");

  property p_trig_pass;
    @(posedge CLK) disable iff (!RST_B)
    (CE && REG_WR && REG_ADDR == pac_pkg::ADDR_OSC_LINK
     && !cal_r[pac_pkg::CAL_NOTRIG_BIT]) |=> OSC_LINK_TRIGGER;
  endproperty
  a_trig_pass: assert property (p_trig_pass)
    else $error("Link trigger missing");

  property p_meas;
    @(posedge CLK) disable iff (!RST_B)
    CE && (cal_r[2:0] == 3'd6) |=> (CAL_CTRL.meas_cycles == 9'd128);
  endproperty
  a_meas: assert property (p_meas)
    else $error("Measurement length wrong");

  property p_curve;
    @(posedge CLK) disable iff (!RST_B)
    CE && (cal_r[5:3] == 3'd4) |=> (CAL_CTRL.curve_offset == -4'sd4);
  endproperty
  a_curve: assert property (p_curve)
    else $error("Curve offset wrong");

  property p_exact;
    @(posedge CLK) disable iff (!RST_B)
    CE && (exact_r < 14'd2) |=> !EXACT_ENABLE;
  endproperty
  a_exact: assert property (p_exact)
    else $error("Exact mode enabled below two");

  property p_readback;
    @(posedge CLK) disable iff (!RST_B)
    (CE && REG_WR && REG_ADDR == pac_pkg::ADDR_DET)
      ##1 (CE && REG_RD && !REG_WR && REG_ADDR == pac_pkg::ADDR_DET)
      |=> (REG_RDATA == $past(REG_WDATA, 2));
  endproperty
  a_readback: assert property (p_readback)
    else $error("Read back differs from write");

  property p_up_gate;
    @(posedge CLK) disable iff (!RST_B)
    CE && !det_r[5] |=> !DET_CTRL.up_enable;
  endproperty
  a_up_gate: assert property (p_up_gate)
    else $error("Up output not gated");

  property p_polarity;
    @(posedge CLK) disable iff (!RST_B)
    CE |=> (DET_CTRL.polarity_inverted == $past(det_r[4]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("Polarity control wrong");

  property p_gating;
    @(posedge CLK) disable iff (!RST_B)
    CE |=> (DET_CTRL.counter_clock_gating == $past(det_r[18:17]));
  endproperty
  a_gating: assert property (p_gating)
    else $error("Counter gating control wrong");
endmodule // pac_config_regs
`default_nettype wire

// ===== test/tb_pac_config_regs.sv
// Self-checking bench for the configuration bank, driven at falling edges.
// Assumes pac_pkg and pac_config_regs are compiled before this file.
`default_nettype none
module tb_pac_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [8:0] MEAS_T [8] = '{9'h001, 9'h002, 9'h004, 9'h008,
    9'h020, 9'h040, 9'h080, 9'h100};
  localparam logic [23:0] TICKS_T [4] = '{24'h000020, 24'h000008,
    24'h000002, 24'h000001};
  logic clk, rst_b, ce, reg_wr, reg_rd, ref_pin, cal_tick, osc_trig, exact_en;
  logic [5:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, rd_val, w;
  logic [6:0] wait_len;
  logic [13:0] exact_ch;
  logic [2:0] c;
  pac_pkg::pac_cal_ctrl_s cal_ctrl;
  pac_pkg::pac_det_ctrl_s det_ctrl;
  int err_count, samples_checked, trig_cnt, tick_cnt, tick_t;

  pac_config_regs dut (.CLK(clk), .RST_B(rst_b), .CE(ce),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REF_PIN(ref_pin),
    .CAL_TICK(cal_tick), .CAL_CTRL(cal_ctrl), .CAL_WAIT_LEN(wait_len),
    .OSC_LINK_TRIGGER(osc_trig), .DET_CTRL(det_ctrl),
    .EXACT_CHANNELS(exact_ch), .EXACT_ENABLE(exact_en));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Reference of 40 ns period, edges on falling clock edges
  initial begin
    ref_pin = 1'b0;
    forever #20 ref_pin = ~ref_pin;
  end
  // Pulses are counted where they are settled, away from launching edges
  always @(negedge clk) begin
    if (osc_trig === 1'b1) trig_cnt++;
    if (cal_tick === 1'b1) begin
      tick_cnt++;
      tick_t = int'($time);
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask

  task automatic t_reset();
    rd(pac_pkg::ADDR_CAL);
    chk(rd_val, pac_pkg::RST_CAL);
    rd(pac_pkg::ADDR_DET);
    chk(rd_val, pac_pkg::RST_DET);
    rd(pac_pkg::ADDR_EXACT);
    chk(rd_val, pac_pkg::RST_EXACT);
    chk({15'h0, cal_ctrl.meas_cycles}, 24'h000040);
    chk({22'h0, cal_ctrl.curve_search_bit_count}, 24'h000002);
    chk({17'h0, wait_len}, 24'h000064);
    chk({21'h0, det_ctrl.reset_delay}, 24'h000001);
    chk({22'h0, det_ctrl.up_enable, det_ctrl.down_enable}, 24'h3);
    chk({22'h0, det_ctrl.counter_clock_gating}, 24'h000003);
    chk({23'h0, exact_en}, 24'h000000);
  endtask

  task automatic t_cal();
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      w = {7'h00, c[2], c[0], c[1:0], 1'b0, c[1], c[0], c[1:0], c[1:0], c, c};
      wr(pac_pkg::ADDR_CAL, w);
      rd(pac_pkg::ADDR_CAL);
      chk(rd_val, w);
      chk({15'h0, cal_ctrl.meas_cycles}, {15'h0, MEAS_T[i]});
      chk({20'h0, cal_ctrl.curve_offset}, {20'h0, c[2], c});
      chk({22'h0, cal_ctrl.wait_after_cycles}, {22'h0, c[1:0]});
      chk({22'h0, cal_ctrl.curve_search_bit_count}, {22'h0, c[1:0]});
      chk({22'h0, cal_ctrl.bypass_tuning, cal_ctrl.force_curve},
        {22'h0, c[1], c[0]});
    end
    wr(pac_pkg::ADDR_CAL, pac_pkg::RST_CAL);
  endtask

  task automatic t_det();
    for (int i = 0; i < 4; i++) begin
      c = i[2:0];
      w = 24'h800a5e | {15'h0, c[1:0], 7'h00} | {5'h00, c[1:0], 17'h0};
      wr(pac_pkg::ADDR_DET, w);
      rd(pac_pkg::ADDR_DET);
      chk(rd_val, w);
      chk({21'h0, det_ctrl.reset_delay}, 24'h000006);
      chk({22'h0, det_ctrl.inputs_shorted, det_ctrl.polarity_inverted},
        24'h000003);
      chk({22'h0, det_ctrl.up_enable, det_ctrl.down_enable}, 24'h1);
      chk({22'h0, det_ctrl.cycle_slip_select}, {22'h0, c[1:0]});
      chk({21'h0, det_ctrl.force_up, det_ctrl.force_down,
        det_ctrl.force_mid_rail}, 24'h000005);
      chk({22'h0, det_ctrl.counter_clock_gating}, {22'h0, c[1:0]});
    end
    // Read taken at the edge right after the write
    @(negedge clk);
    reg_addr = pac_pkg::ADDR_DET;
    reg_wdata = 24'h0f8063;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, 24'h0f8063);
    wr(pac_pkg::ADDR_DET, pac_pkg::RST_DET);
  endtask

  task automatic t_exact();
    logic [23:0] vals [4];
    vals = '{24'h000000, 24'h000001, 24'hffc002, 24'h003fff};
    for (int i = 0; i < 4; i++) begin
      wr(pac_pkg::ADDR_EXACT, vals[i]);
      rd(pac_pkg::ADDR_EXACT);
      chk(rd_val, vals[i] & 24'h003fff);
      chk({10'h0, exact_ch}, vals[i] & 24'h003fff);
      chk({23'h0, exact_en}, {23'h0, vals[i][13:0] >= 14'h0002});
    end
    ce = 1'b0;
    wr(pac_pkg::ADDR_EXACT, 24'h000077);
    ce = 1'b1;
    rd(pac_pkg::ADDR_EXACT);
    chk(rd_val, 24'h003fff);
    rd(6'h0d);
    chk(rd_val, 24'h000000);
    wr(6'h0d, 24'hffffff);
    rd(pac_pkg::ADDR_CAL);
    chk(rd_val, pac_pkg::RST_CAL);
  endtask

  task automatic t_trig();
    trig_cnt = 0;
    wr(pac_pkg::ADDR_OSC_LINK, 24'h000000);
    idle(3);
    chk(trig_cnt[23:0], 24'h000001);
    wr(pac_pkg::ADDR_CAL, pac_pkg::RST_CAL | 24'h001000);
    trig_cnt = 0;
    wr(pac_pkg::ADDR_OSC_LINK, 24'h000000);
    idle(3);
    chk(trig_cnt[23:0], 24'h000000);
    wr(pac_pkg::ADDR_CAL, pac_pkg::RST_CAL);
  endtask

  task automatic t_tick();
    for (int i = 0; i < 4; i++) begin
      c = i[2:0];
      wr(pac_pkg::ADDR_CAL, (pac_pkg::RST_CAL & 24'hff1fff)
        | {8'h00, c[0], c[1:0], 13'h0000});
      idle(300);
      @(posedge clk);
      tick_cnt = 0;
      idle(256);
      @(posedge clk);
      chk(tick_cnt[23:0], TICKS_T[i]);
      // Rising pin edges fall at 20 mod 40 ns, falling ones at 0 mod 40
      chk(24'(tick_t % 40), c[0] ? 24'h000014 : 24'h000000);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #50us;
    err_count++;
    summarize();
  end
  initial begin
    err_count = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 24'h000000;
    idle(12);
    rst_b = 1'b1;
    idle(3);
    t_reset();
    t_cal();
    t_det();
    t_exact();
    t_trig();
    t_tick();
    summarize();
  end
endmodule // tb_pac_config_regs
`default_nettype wire
